// ==== design/bitplane_pwm_sequencer.sv ====
`timescale 1ns/1ps
// Summary of operation
// - accept 24/27/30-bit RGB, at most 120 Hz
// - frame split equally into three color slots
// - one bit-plane per bit of color depth
// - plane duration proportional to two-power weight
// - 8-bit slot weights sum to 255 units
// - mirror on exactly when plane bit set
// - frame held as 24/27/30 planes, sent singly
// - exposure time follows plane binary weight
// - pattern mode places planes into depth slots
// - pattern mode trigger aligned with plane slots
// - memory holds two independent frame halves
// - fill one half while other displays
// - halves swap when frame display completes and the fill is done
// - display lags streamed input by one frame
// - advance pulse steps to next pattern
// - exposure output framed over each exposure
// - start pulse per sequence; run input gates pattern mode only
module bitplane_pwm_sequencer
  import bitplane_pkg::*;
#(
  parameter int NPIX     = NPIX_DEF,
  parameter int SLOT_CYC = SLOT_CYC_DEF
) (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rst_b,
  // configuration
  input  wire logic            pattern_mode,
  input  wire logic [1:0]      depth_sel,
  input  wire logic            src_sel,
  // pixel sources
  input  wire pix_in_t         rgb_in,
  output logic                 rgb_ready,
  input  wire pix_in_t         flash_in,
  output logic                 flash_ready,
  // triggers
  input  wire logic            advance_pattern_in,
  input  wire logic            sequence_run_in,
  output logic                 exposure_frame_out,
  output logic                 sequence_start_out,
  // mirror array
  output logic [NPIX-1:0]      mirror_array
);

  localparam int IW = $clog2(NPIX);

  ////////////////////////////////////////////////////////////////////
  function automatic logic [4:0] plane_idx(input logic [1:0] color,
                                           input logic [3:0] bitn,
                                           input logic [3:0] depth);
    logic [7:0] off;
    off = 8'(COLOR_LAST - color) * 8'(depth) + 8'(bitn);
    return off[4:0];
  endfunction : plane_idx

  ////////////////////////////////////////////////////////////////////
  logic [1:0] rst_sync_q;
  logic       rst_sync_b;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////
  seq_state_t        state_q;
  logic              disp_q;
  logic              shown_q;
  logic              fill_done_q;
  logic [IW-1:0]     wr_idx_q;
  logic [3:0]        depth_q;
  logic [1:0]        color_q;
  logic [3:0]        bit_q;
  logic [31:0]       cnt_q;
  logic              seq_start_q;
  logic [NPIX-1:0]   mirror_q;
  logic [PIX_W-1:0]  mem_q [HALVES][NPIX];

  pix_in_t           pix;
  logic              wr_en;
  logic              fill_half;
  logic [3:0]        sel_depth;
  logic              plane_done;
  logic              last_plane;
  logic              frame_end;
  logic              start;
  logic              new_frame;
  logic              swap;
  logic              nxt_half;
  logic [3:0]        nxt_depth;
  logic [1:0]        nxt_color;
  logic [3:0]        nxt_bit;
  logic [4:0]        nxt_idx;
  logic [31:0]       unit_cyc;
  logic [31:0]       nxt_len;

  ////////////////////////////////////////////////////////////////////
  // depth 8/9/10 gives 24/27/30-bit words; unused code falls to 10
  always_comb begin
    if (depth_sel == DEPTH_SEL_8) begin
      sel_depth = DEPTH_MIN;
    end else if (depth_sel == DEPTH_SEL_9) begin
      sel_depth = DEPTH_MIN + 4'h1;
    end else begin
      sel_depth = DEPTH_MAX;
    end
  end

  // the shown half is never the fill target
  assign pix         = src_sel ? flash_in : rgb_in;
  assign fill_half   = ~disp_q;
  // one new frame per displayed frame caps the input rate
  assign wr_en       = pix.valid & ~fill_done_q;
  assign rgb_ready   = ~fill_done_q & ~src_sel;
  assign flash_ready = ~fill_done_q & src_sel;

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem_q[fill_half][wr_idx_q] <= pix.data;
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign plane_done = (state_q == ST_SHOW) && (cnt_q == 32'h1);
  assign last_plane = (bit_q == depth_q - 4'h1);
  assign frame_end  = last_plane && (color_q == COLOR_LAST);

  always_comb begin
    start = 1'b0;
    case (state_q)
      ST_IDLE: begin
        start = (fill_done_q | shown_q) & (~pattern_mode | sequence_run_in);
      end
      ST_SHOW: begin
        start = plane_done & ~pattern_mode;
      end
      ST_WAIT: begin
        start = advance_pattern_in & sequence_run_in;
      end
      default: begin
        start = 1'b0;
      end
    endcase
  end

  // depth and half only change between frames
  assign new_frame = (state_q == ST_IDLE) | frame_end;
  assign swap      = start & new_frame & fill_done_q;
  assign nxt_half  = swap ? ~disp_q : disp_q;
  assign nxt_depth = new_frame ? sel_depth : depth_q;

  always_comb begin
    if (new_frame) begin
      nxt_color = 2'h0;
      nxt_bit   = 4'h0;
    end else if (last_plane) begin
      nxt_color = color_q + 2'h1;
      nxt_bit   = 4'h0;
    end else begin
      nxt_color = color_q;
      nxt_bit   = bit_q + 4'h1;
    end
  end

  // slot / 2^depth per unit: weights fill 255/511/1023 of a slot's 256/512/1024 units
  assign unit_cyc = 32'(SLOT_CYC) >> nxt_depth;
  assign nxt_len  = unit_cyc << nxt_bit;
  assign nxt_idx  = plane_idx(nxt_color, nxt_bit, nxt_depth);

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_q <= ST_IDLE;
      cnt_q   <= 32'h0;
    end else if (start) begin
      state_q <= ST_SHOW;
      cnt_q   <= nxt_len;
    end else if (state_q == ST_SHOW) begin
      cnt_q <= cnt_q - 32'h1;
      if (plane_done) begin
        state_q <= ST_WAIT;
      end
    end else if (state_q == ST_WAIT && !sequence_run_in) begin
      state_q <= ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      depth_q <= DEPTH_MIN;
      color_q <= 2'h0;
      bit_q   <= 4'h0;
    end else if (start) begin
      depth_q <= nxt_depth;
      color_q <= nxt_color;
      bit_q   <= nxt_bit;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      disp_q  <= 1'b0;
      shown_q <= 1'b0;
    end else if (swap) begin
      disp_q  <= ~disp_q;
      shown_q <= 1'b1;
    end
  end

  // swap is gated by fill_done, so a last word and a swap never collide
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      fill_done_q <= 1'b0;
      wr_idx_q    <= '0;
    end else if (swap) begin
      fill_done_q <= 1'b0;
      wr_idx_q    <= '0;
    end else if (wr_en) begin
      wr_idx_q <= wr_idx_q + IW'(1);
      if (pix.last || wr_idx_q == IW'(NPIX - 1)) begin
        fill_done_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // one plane at a time from the shown half
  for (genvar p = 0; p < NPIX; p++) begin : g_mirror
    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        mirror_q[p] <= 1'b0;
      end else if (start) begin
        mirror_q[p] <= mem_q[nxt_half][p][nxt_idx];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      seq_start_q <= 1'b0;
    end else begin
      seq_start_q <= start & new_frame;
    end
  end

  assign mirror_array       = mirror_q;
  assign exposure_frame_out = (state_q == ST_SHOW);
  assign sequence_start_out = seq_start_q;

  ////////////////////////////////////////////////////////////////////
  sequence s_plane_end;
    plane_done && !frame_end;
  endsequence

  sequence s_wait_adv;
    (state_q == ST_WAIT) && advance_pattern_in && sequence_run_in;
  endsequence

  a_fill_half_guard: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    wr_en |-> fill_half != disp_q)
    else $error("write aimed at the displayed half");

  a_swap_boundary: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    $changed(disp_q) |-> $past(new_frame) && $past(fill_done_q))
    else $error("half swap away from a frame boundary");

  a_plane_length: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    start |=> cnt_q == ((32'(SLOT_CYC) >> depth_q) << bit_q))
    else $error("plane length does not match its weight");

  // a short slot can make a plane one cycle long, so start may rise again at once
  a_plane_order: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    s_plane_end ##0 !pattern_mode |=> exposure_frame_out ##0
    ((bit_q == 4'h0 && color_q == $past(color_q) + 2'h1)
      || (bit_q == $past(bit_q) + 4'h1 && color_q == $past(color_q))))
    else $error("bit-plane order broken");

  a_mirror_bit: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    start |=> mirror_array[0] ==
      mem_q[disp_q][0][plane_idx(color_q, bit_q, depth_q)])
    else $error("mirror does not follow plane bit");

  a_advance_step: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    s_wait_adv |=> exposure_frame_out && !$past(exposure_frame_out))
    else $error("advance pulse did not start a plane");

  a_wait_hold: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    (state_q == ST_WAIT) && !advance_pattern_in && sequence_run_in
      |=> !exposure_frame_out)
    else $error("pattern advanced without a pulse");

  a_seq_start: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    sequence_start_out |-> exposure_frame_out && bit_q == 4'h0
      && color_q == 2'h0 ##1 !sequence_start_out)
    else $error("sequence start away from frame start");

  a_frame_lag: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    frame_end && plane_done && !pattern_mode && fill_done_q
      |=> $changed(disp_q) && !fill_done_q)
    else $error("filled frame not shown at next frame");

  a_unit_sum: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    exposure_frame_out |-> (((32'(SLOT_CYC) >> depth_q) << depth_q)
      <= 32'(SLOT_CYC)) && depth_q >= DEPTH_MIN && depth_q <= DEPTH_MAX)
    else $error("depth outside 8 to 10");

endmodule : bitplane_pwm_sequencer

// ==== shared/bitplane_pkg.sv ====
package bitplane_pkg;

  // timing at a 100 MHz ref_clk
  localparam int CLK_MHZ       = 100;
  localparam int SLOT_TIME_US  = 2780;
  localparam int SLOT_CYC_DEF  = SLOT_TIME_US * CLK_MHZ;
  localparam int FRAME_HZ_MAX  = 120;

  // picture format
  localparam int PIX_W         = 30;
  localparam int COLORS        = 3;
  localparam int HALVES        = 2;
  localparam int PLANES_HALF   = 24;
  localparam int NPIX_DEF      = 16;

  // color depth select codes
  localparam logic [1:0] DEPTH_SEL_8  = 2'h0;
  localparam logic [1:0] DEPTH_SEL_9  = 2'h1;
  localparam logic [1:0] DEPTH_SEL_10 = 2'h2;
  localparam logic [3:0] DEPTH_MIN    = 4'h8;
  localparam logic [3:0] DEPTH_MAX    = 4'ha;
  localparam logic [1:0] COLOR_LAST   = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHOW,
    ST_WAIT
  } seq_state_t;

  typedef struct packed {
    logic             valid;
    logic             last;
    logic [PIX_W-1:0] data;
  } pix_in_t;

endpackage : bitplane_pkg

// ==== verif/pixel_source_model.sv ====
`timescale 1ns/1ps
module pixel_source_model
  import bitplane_pkg::*;
(
  // clock
  input  wire logic ref_clk,
  // source select and handshake
  input  wire logic src_sel,
  input  wire logic rgb_ready,
  input  wire logic flash_ready,
  output pix_in_t   rgb_in,
  output pix_in_t   flash_in
);
  logic [PIX_W-1:0] q[$];
  logic             tog_q = 1'b0;
  initial begin
    rgb_in   = '0;
    flash_in = '0;
  end
  // idle lines toggle so stale words never look valid by accident
  always @(posedge ref_clk) begin
    pix_in_t w;
    pix_in_t idle;
    if (q.size() != 0 && (src_sel ? flash_in.valid && flash_ready : rgb_in.valid && rgb_ready))
      void'(q.pop_front());
    idle  = '{valid: 1'b0, last: 1'b0, data: {PIX_W{tog_q}}};
    w     = idle;
    if (q.size() != 0) w = '{valid: 1'b1, last: 1'b0, data: q[0]};
    tog_q    <= ~tog_q;
    rgb_in   <= src_sel ? idle : w;
    flash_in <= src_sel ? w : idle;
  end
endmodule : pixel_source_model

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import bitplane_pkg::*;
  localparam int NP = 4;
  localparam int SC = 1024;
  logic ref_clk = 0, rst_b = 0, pattern_mode = 0, src_sel = 0;
  logic advance_pattern_in = 0, sequence_run_in = 0;
  logic [1:0] depth_sel = 2'h0;
  pix_in_t rgb_in, flash_in;
  logic rgb_ready, flash_ready, exposure_frame_out, sequence_start_out;
  logic [NP-1:0] mirror_array;
  int n_errors = 0, cmp_count = 0;
  logic [PIX_W-1:0] frm [2][NP];
  always #5 ref_clk = ~ref_clk;
  bitplane_pwm_sequencer #(.NPIX(NP), .SLOT_CYC(SC)) DUT (
    .ref_clk(ref_clk), .rst_b(rst_b), .pattern_mode(pattern_mode), .depth_sel(depth_sel),
    .src_sel(src_sel), .rgb_in(rgb_in), .rgb_ready(rgb_ready), .flash_in(flash_in),
    .flash_ready(flash_ready), .advance_pattern_in(advance_pattern_in),
    .sequence_run_in(sequence_run_in), .exposure_frame_out(exposure_frame_out),
    .sequence_start_out(sequence_start_out), .mirror_array(mirror_array));
  pixel_source_model u_src (
    .ref_clk(ref_clk), .src_sel(src_sel), .rgb_ready(rgb_ready), .flash_ready(flash_ready),
    .rgb_in(rgb_in), .flash_in(flash_in));
  ////////////////////////////////////////////////////////////////////////////////
  task conclude;
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  function automatic logic [NP-1:0] plane_bits(int f, int d, int c, int b);
    logic [NP-1:0] r;
    for (int p = 0; p < NP; p++) r[p] = frm[f][p][(2-c)*d+b];
    return r;
  endfunction : plane_bits
  ////////////////////////////////////////////////////////////////////////////////
  task do_reset;
    @(posedge ref_clk) rst_b <= 1'b0;
    repeat (6) @(posedge ref_clk);
    check("reset_mirror", mirror_array, 0);
    check("reset_exposure", exposure_frame_out, 0);
    check("reset_ready", {rgb_ready, flash_ready}, {~src_sel, src_sel});
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask : do_reset
  // pixel 0 is all ones as a fixed corner, the rest random
  task load_frame(input int f, input int d);
    for (int p = 0; p < NP; p++) begin
      frm[f][p] = $urandom & ((32'h1 << (3*d)) - 1);
      if (p == 0) frm[f][p] = (32'h1 << (3*d)) - 1;
      u_src.q.push_back(frm[f][p]);
    end
  endtask : load_frame
  // called at the negedge of a plane's first cycle
  task show_plane(input int f, input int d, input int c, input int b, input bit pat);
    int len;
    len = (SC >> d) << b;
    check("mirror", mirror_array, plane_bits(f, d, c, b));
    check("exposure", exposure_frame_out, 1);
    check("seq_start", sequence_start_out, (c == 0 && b == 0));
    repeat (len - 1) @(negedge ref_clk);
    check("mirror_end", mirror_array, plane_bits(f, d, c, b));
    check("exposure_end", exposure_frame_out, 1);
    @(negedge ref_clk);
    if (pat) check("exposure_gap", exposure_frame_out, 0);
  endtask : show_plane
  task wait_start;
    for (int k = 0; k < 20000 && sequence_start_out !== 1'b1; k++) @(negedge ref_clk);
    check("frame_start", sequence_start_out, 1);
  endtask : wait_start
  task show_frame(input int f, input int d);
    wait_start();
    for (int c = 0; c < 3; c++)
      for (int b = 0; b < d; b++) begin
        // by the green slot the next frame (queued only behind frame 0) is in
        if (c == 1 && b == 0) begin
          check("ready", src_sel ? flash_ready : rgb_ready, (f == 0) ? 0 : 1);
          check("ready_other", src_sel ? rgb_ready : flash_ready, 0);
        end
        show_plane(f, d, c, b, 1'b0);
      end
  endtask : show_frame
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge ref_clk);
    n_errors++;
    conclude();
  end
  initial begin
    int d;
    void'($urandom(90));
    // every depth code, both sources; lag, swap and repeat of a held frame
    for (int code = 0; code < 4; code++) begin
      d = (code == 0) ? 8 : (code == 1) ? 9 : 10;
      @(posedge ref_clk);
      depth_sel <= code[1:0];
      src_sel   <= code[1];
      do_reset();
      load_frame(0, d);
      load_frame(1, d);
      show_frame(0, d);
      show_frame(1, d);
      show_frame(1, d);
    end
    // pattern operation: each plane after the first waits for an advance pulse
    @(posedge ref_clk);
    pattern_mode    <= 1'b1;
    sequence_run_in <= 1'b1;
    depth_sel       <= 2'h0;
    src_sel         <= 1'b0;
    do_reset();
    load_frame(0, 8);
    wait_start();
    show_plane(0, 8, 0, 0, 1'b1);
    for (int b = 1; b < 4; b++) begin
      repeat (20) @(negedge ref_clk);
      check("held_dark", exposure_frame_out, 0);
      @(posedge ref_clk) advance_pattern_in <= 1'b1;
      @(posedge ref_clk) advance_pattern_in <= 1'b0;
      @(negedge ref_clk);
      for (int k = 0; k < 50 && exposure_frame_out !== 1'b1; k++) @(negedge ref_clk);
      show_plane(0, 8, 0, b, 1'b1);
    end
    // run low stops the sequence even with an advance
    @(posedge ref_clk) sequence_run_in <= 1'b0;
    @(posedge ref_clk) advance_pattern_in <= 1'b1;
    @(posedge ref_clk) advance_pattern_in <= 1'b0;
    repeat (100) @(negedge ref_clk);
    check("stopped", exposure_frame_out, 0);
    conclude();
  end
endmodule : testbench
